// >>> rtcpw_map.svh
// offsets, field positions, reset values and timing counts of the
// periodic wake-up timer; bit positions are little-endian (bit 31 = msb)
`ifndef RTCPW_MAP_SVH
`define RTCPW_MAP_SVH
`define RTCPW_OFS_CTRL      32'h0000_0000
`define RTCPW_OFS_STATUS    32'h0000_0004
`define RTCPW_OFS_COUNT     32'h0000_0008
`define RTCPW_CTRL_RESET    32'h0000_0000
`define RTCPW_B_CNT_EN      31
`define RTCPW_B_CMP_IE      30
`define RTCPW_B_FRZ_EN      29
`define RTCPW_B_ROVR_EN     28
`define RTCPW_F_CMPVAL      27:16
`define RTCPW_B_PER_EN      15
`define RTCPW_B_PER_IE      14
`define RTCPW_F_COUNTER_CLOCK_SELECT      13:12
`define RTCPW_B_DIV512      11
`define RTCPW_B_DIV32       10
`define RTCPW_F_PERVAL      9:0
`define RTCPW_B_ST_CMP      0
`define RTCPW_B_ST_PER      1
`define RTCPW_B_ST_ROVR     2
`define RTCPW_DIV512_LAST   9'h1ff
`define RTCPW_DIV32_LAST    5'h1f
`define RTCPW_CNT_MAX       32'hffff_ffff
`define RTCPW_RESP_OKAY     2'b00
`define RTCPW_RESP_SLVERR   2'b10
`endif

// >>> rtcpw_pkg.sv
// types shared by the periodic wake-up timer
// assumes nothing of its surroundings
package rtcpw_pkg;
  // counter clock sources
  typedef enum logic [1:0] {
    RTCPW_SLOW_CRYSTAL_OSC = 2'h0,
    RTCPW_SLOW_INTERNAL_RC = 2'h1,
    RTCPW_FAST_INTERNAL_RC = 2'h2,
    RTCPW_CLK_RESERVED     = 2'h3
  } rtcpw_clk_sel_t;
endpackage : rtcpw_pkg

// >>> rtcpw_timer.sv
// wake-up counter with compare and periodic timers behind AXI4-Lite
// assumes oscillator levels synchronous to clock_i and far slower than it
//
// What this block does
// - enable low holds counter logic in reset
// - compare flag and enable raise interrupt
// - freeze holds counter during debug mode
// - rollover wakes; interrupt needs compare enable
// - compare value matches counter bits 21:10
// - periodic events only while periodic enabled
// - periodic flag and enable raise interrupt
// - clock select picks crystal, slow or fast
// - divide-by-512 prescaler when enabled
// - divide-by-32 prescaler when enabled
// - periodic value matches counter low ten bits
// - periodic value synchronised, first event late
// - periodic needs nonzero value, minimum four; the logic blocks only zero, values 1 to 3 still match
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "rtcpw_map.svh"

module rtcpw_timer
  import rtcpw_pkg::*;
(
  input  wire logic        clock_i,         // 10 mhz system clock
  input  wire logic        nrst_i,          // synchronous, active low
  input  wire logic        slow_crystal_osc_i,
  input  wire logic        slow_internal_rc_i,
  input  wire logic        fast_internal_rc_i,
  input  wire logic        debug_mode_i,    // core in debug mode
  output logic             compare_irq_o,   // compare / rollover request
  output logic             periodic_irq_o,  // periodic request
  output logic             wakeup_o,        // wake-up request level
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0]    ctrl_q;          // control register
  logic [31:0]    cnt_q;           // wake-up counter
  logic [31:0]    cnt_d;           // counter plus one
  logic           cmp_flag_q;      // compare match flag
  logic           per_flag_q;      // periodic flag
  logic           rovr_flag_q;     // rollover flag
  logic           src_prev_q;      // selected source, last cycle
  logic [8:0]     div512_q;        // first prescaler
  logic [4:0]     div32_q;         // second prescaler
  logic [9:0]     per_s1_q;        // periodic value, first stage
  logic [9:0]     per_s2_q;        // periodic value, in counter domain
  logic           run_clr;         // counter logic held in reset
  logic           src_lvl;         // selected oscillator level
  logic           src_rise;        // rising edge of selected source
  logic           tick_a;          // after divide-by-512
  logic           tick_b;          // after divide-by-32
  logic           tick;            // counter step
  logic           cmp_hit;         // compare match event
  logic           per_hit;         // periodic match event
  logic           rovr_hit;        // rollover event
  logic           wr_go;           // write taken
  logic           st_clr_cmp;      // software clears compare flag
  logic           st_clr_per;      // software clears periodic flag
  logic           st_clr_rovr;     // software clears rollover flag
  logic [31:0]    wr_mask;         // byte-lane mask from strobes
  logic [31:0]    rd_word;         // read mux
  logic           rd_ok;           // read address mapped
  rtcpw_clk_sel_t clk_sel;         // decoded clock select

  ////////////////////////////////////////////////////////////////////////
  // control fields
  assign run_clr = !nrst_i || !ctrl_q[`RTCPW_B_CNT_EN];
  assign clk_sel = rtcpw_clk_sel_t'(ctrl_q[`RTCPW_F_COUNTER_CLOCK_SELECT]);

  ////////////////////////////////////////////////////////////////////////
  // clock source selection and edge detect
  always_comb begin
    unique case (clk_sel)
      RTCPW_SLOW_CRYSTAL_OSC: src_lvl = slow_crystal_osc_i;
      RTCPW_SLOW_INTERNAL_RC: src_lvl = slow_internal_rc_i;
      RTCPW_FAST_INTERNAL_RC: src_lvl = fast_internal_rc_i;
      RTCPW_CLK_RESERVED:     src_lvl = 1'b0;
    endcase
  end

  // previous level of the selected source
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      src_prev_q <= 1'b1;
    end else begin
      src_prev_q <= src_lvl;
    end
  end

  assign src_rise = src_lvl && !src_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // prescalers: 512 first, then 32
  assign tick_a = src_rise && (!ctrl_q[`RTCPW_B_DIV512] ||
                  div512_q == `RTCPW_DIV512_LAST);
  assign tick_b = tick_a && (!ctrl_q[`RTCPW_B_DIV32] ||
                  div32_q == `RTCPW_DIV32_LAST);
  // debug freeze drops ticks, counter keeps its value
  assign tick   = tick_b && !(ctrl_q[`RTCPW_B_FRZ_EN] && debug_mode_i);

  // divide-by-512 counter
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      div512_q <= 9'h000;
    end else if (src_rise && ctrl_q[`RTCPW_B_DIV512]) begin
      div512_q <= div512_q + 9'h001;
    end
  end

  // divide-by-32 counter
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      div32_q <= 5'h00;
    end else if (tick_a && ctrl_q[`RTCPW_B_DIV32]) begin
      div32_q <= div32_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main counter
  assign cnt_d = cnt_q + 32'h0000_0001;

  // counter steps per tick and wraps to zero
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // periodic value moved into counter domain on two ticks
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      per_s1_q <= 10'h000;
      per_s2_q <= 10'h000;
    end else if (tick) begin
      per_s1_q <= ctrl_q[`RTCPW_F_PERVAL];
      per_s2_q <= per_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // match events, evaluated on the value the counter takes
  assign cmp_hit  = tick && cnt_d[21:10] == ctrl_q[`RTCPW_F_CMPVAL];
  assign per_hit  = tick && ctrl_q[`RTCPW_B_PER_EN] &&
                    per_s2_q != 10'h000 &&
                    cnt_d[9:0] == per_s2_q;
  assign rovr_hit = tick && cnt_q == `RTCPW_CNT_MAX;

  ////////////////////////////////////////////////////////////////////////
  // status flags: set wins over software clear
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      cmp_flag_q <= 1'b0;
    end else if (cmp_hit) begin
      cmp_flag_q <= 1'b1;
    end else if (st_clr_cmp) begin
      cmp_flag_q <= 1'b0;
    end
  end

  // periodic flag
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      per_flag_q <= 1'b0;
    end else if (per_hit) begin
      per_flag_q <= 1'b1;
    end else if (st_clr_per) begin
      per_flag_q <= 1'b0;
    end
  end

  // rollover flag, only when rollover events are enabled
  always_ff @(posedge clock_i) begin
    if (run_clr) begin
      rovr_flag_q <= 1'b0;
    end else if (rovr_hit && ctrl_q[`RTCPW_B_ROVR_EN]) begin
      rovr_flag_q <= 1'b1;
    end else if (st_clr_rovr) begin
      rovr_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // requests toward the system
  assign compare_irq_o  = ctrl_q[`RTCPW_B_CMP_IE] &&
                          (cmp_flag_q || rovr_flag_q);
  assign periodic_irq_o = ctrl_q[`RTCPW_B_PER_IE] && per_flag_q;
  assign wakeup_o       = cmp_flag_q || per_flag_q || rovr_flag_q;

  ////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken together
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  // byte enables to bit mask
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wr_mask[8*b +: 8] = {8{s_axi_wstrb[b]}};
  end

  // write-one-to-clear of status bits
  assign st_clr_cmp  = wr_go && s_axi_awaddr == `RTCPW_OFS_STATUS &&
                       s_axi_wstrb[0] && s_axi_wdata[`RTCPW_B_ST_CMP];
  assign st_clr_per  = wr_go && s_axi_awaddr == `RTCPW_OFS_STATUS &&
                       s_axi_wstrb[0] && s_axi_wdata[`RTCPW_B_ST_PER];
  assign st_clr_rovr = wr_go && s_axi_awaddr == `RTCPW_OFS_STATUS &&
                       s_axi_wstrb[0] && s_axi_wdata[`RTCPW_B_ST_ROVR];

  // control register write
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ctrl_q <= `RTCPW_CTRL_RESET;
    end else if (wr_go && s_axi_awaddr == `RTCPW_OFS_CTRL) begin
      ctrl_q <= (ctrl_q & ~wr_mask) | (s_axi_wdata & wr_mask);
    end
  end

  // write response, error on unmapped or read-only address
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RTCPW_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr == `RTCPW_OFS_CTRL ||
                       s_axi_awaddr == `RTCPW_OFS_STATUS) ?
                      `RTCPW_RESP_OKAY : `RTCPW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read channel
  assign s_axi_arready = !s_axi_rvalid;

  // read mux
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `RTCPW_OFS_CTRL:   rd_word = ctrl_q;
      `RTCPW_OFS_STATUS: rd_word = {29'h0000_0000, rovr_flag_q,
                                    per_flag_q, cmp_flag_q};
      `RTCPW_OFS_COUNT:  rd_word = cnt_q;
      default:           rd_ok   = 1'b0;
    endcase
  end

  // read data and response
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RTCPW_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `RTCPW_RESP_OKAY : `RTCPW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions and covers
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  chk_disable_clears: assert property (
    !ctrl_q[`RTCPW_B_CNT_EN] |=> cnt_q == 32'h0 && !cmp_flag_q &&
      !per_flag_q && !rovr_flag_q)
    else $error("counter logic not cleared while disabled");

  chk_compare_irq: assert property (
    $rose(cmp_flag_q) && ctrl_q[`RTCPW_B_CMP_IE] |-> compare_irq_o)
    else $error("compare match gave no interrupt");

  chk_freeze_hold: assert property (
    ctrl_q[`RTCPW_B_CNT_EN] && ctrl_q[`RTCPW_B_FRZ_EN] && debug_mode_i
      ##1 ctrl_q[`RTCPW_B_CNT_EN] |-> $stable(cnt_q))
    else $error("counter moved while frozen");

  chk_rollover_wake: assert property (
    tick && cnt_q == 32'hffff_ffff && ctrl_q[`RTCPW_B_ROVR_EN] &&
      ctrl_q[`RTCPW_B_CNT_EN] |=> wakeup_o && cnt_q == 32'h0)
    else $error("rollover gave no wake-up");

  chk_compare_set: assert property (
    ctrl_q[`RTCPW_B_CNT_EN] && tick &&
      cnt_d[21:10] == ctrl_q[`RTCPW_F_CMPVAL] |=> cmp_flag_q)
    else $error("compare match flag not set");

  chk_periodic_off: assert property (
    !ctrl_q[`RTCPW_B_PER_EN] && !per_flag_q |=> !per_flag_q)
    else $error("periodic event while disabled");

  chk_periodic_irq: assert property (
    $rose(per_flag_q) |-> periodic_irq_o == ctrl_q[`RTCPW_B_PER_IE])
    else $error("periodic interrupt wrong");

  chk_reserved_clk: assert property (
    ctrl_q[`RTCPW_F_COUNTER_CLOCK_SELECT] == 2'h3 && ctrl_q[`RTCPW_B_CNT_EN] |=>
      $stable(cnt_q))
    else $error("reserved clock select counted");

  chk_count_step: assert property (
    ctrl_q[`RTCPW_B_CNT_EN] && tick ##1 ctrl_q[`RTCPW_B_CNT_EN] |->
      cnt_q == $past(cnt_q) + 32'h1)
    else $error("counter did not step by one");

  chk_flag_sticky: assert property (
    cmp_flag_q && ctrl_q[`RTCPW_B_CNT_EN] && !st_clr_cmp ##1
      ctrl_q[`RTCPW_B_CNT_EN] |-> cmp_flag_q)
    else $error("compare flag dropped by itself");

  cov_compare: cover property ($rose(cmp_flag_q));
  cov_periodic: cover property ($rose(per_flag_q));
  cov_rollover: cover property ($rose(rovr_flag_q));
  cov_freeze: cover property (tick_b && !tick);

endmodule : rtcpw_timer

// >>> test_rtcpw_timer.sv
// self-checking bench for the periodic wake-up timer
// assumes oscillators driven here as slow pulses synchronous to clock_i
`timescale 1ns/1ps
`include "rtcpw_map.svh"

module test_rtcpw_timer;
  import rtcpw_pkg::*;
  localparam logic [31:0] EN   = 32'h1 << `RTCPW_B_CNT_EN;
  localparam logic [31:0] CIE  = 32'h1 << `RTCPW_B_CMP_IE;
  localparam logic [31:0] FRZ  = 32'h1 << `RTCPW_B_FRZ_EN;
  localparam logic [31:0] PEN  = 32'h1 << `RTCPW_B_PER_EN;
  localparam logic [31:0] PIE  = 32'h1 << `RTCPW_B_PER_IE;
  localparam logic [31:0] D512 = 32'h1 << `RTCPW_B_DIV512;
  localparam logic [31:0] D32  = 32'h1 << `RTCPW_B_DIV32;
  localparam logic [31:0] FAST = 32'h0000_2000; // clock select 2
  logic        clock_i = 1'b0;   // 100 ns clock
  logic        nrst_i  = 1'b0;   // active low reset
  logic [2:0]  osc     = 3'h0;   // oscillator levels by select code
  logic        debug   = 1'b0;   // debug mode level
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr  = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0]  rsp;
  logic        cirq, pirq, wake;
  int          miscompares = 0; // mismatches seen
  int          checks_done = 0; // comparisons made

  rtcpw_timer u_dut (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .slow_crystal_osc_i(osc[0]), .slow_internal_rc_i(osc[1]),
    .fast_internal_rc_i(osc[2]), .debug_mode_i(debug),
    .compare_irq_o(cirq), .periodic_irq_o(pirq), .wakeup_o(wake),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  // free-running system clock
  initial begin
    forever #50 clock_i = ~clock_i;
  end

  //////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // compare seen against expected
  task chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : chk

  // a wait that ran out ends the run
  task hang(input int i);
    if (i >= 100) begin
      miscompares++;
      results;
    end
  endtask : hang

  //////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data offered together
  task wr(input logic [31:0] a, d);
    int i;
    @(posedge clock_i);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d;
    bready <= 1'b1;
    i = 0;
    do begin @(posedge clock_i); i++; end
    while (!(awready === 1'b1 && wready === 1'b1) && i < 100);
    hang(i);
    awvalid <= 1'b0; wvalid <= 1'b0;
    i = 0;
    while (bvalid !== 1'b1 && i < 100) begin @(posedge clock_i); i++; end
    hang(i);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  // axi4-lite read, data and response left in rd and rsp
  task rdr(input logic [31:0] a);
    int i;
    @(posedge clock_i);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    i = 0;
    do begin @(posedge clock_i); i++; end
    while (arready !== 1'b1 && i < 100);
    hang(i);
    arvalid <= 1'b0;
    i = 0;
    while (rvalid !== 1'b1 && i < 100) begin @(posedge clock_i); i++; end
    hang(i);
    rd = rdata; rsp = rresp;
    rready <= 1'b0;
  endtask : rdr

  // n source rises on oscillator s, then let the counter settle
  task tick(input int s, input int n);
    repeat (n) begin
      @(posedge clock_i); osc[s] <= 1'b1;
      @(posedge clock_i); osc[s] <= 1'b0;
    end
    repeat (2) @(posedge clock_i);
  endtask : tick

  // restart the counter with a new control word; every source is modelled
  // as already running, and settings change only with the counter off
  task restart(input logic [31:0] c);
    wr(`RTCPW_OFS_CTRL, 32'h0);
    wr(`RTCPW_OFS_CTRL, c);
  endtask : restart

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    rdr(`RTCPW_OFS_CTRL);   chk("ctrl reset", rd, `RTCPW_CTRL_RESET);
    rdr(`RTCPW_OFS_STATUS); chk("status reset", rd, 32'h0);
    rdr(32'h0000_000c);     chk("unmapped", 32'(rsp), 32'h2);
    wr(`RTCPW_OFS_COUNT, 32'h5); chk("count ro", 32'(rsp), 32'h2);
    // each source counts, the next source ignored, disable clears count
    for (int s = 0; s < 3; s++) begin
      restart(EN | (32'(s) << 12));
      tick(s, 3); tick((s + 1) % 3, 2);
      rdr(`RTCPW_OFS_COUNT); chk("count sel", rd, 32'h3);
    end
    restart(EN | 32'h0000_3000);
    tick(0, 2); tick(1, 2); tick(2, 2);
    rdr(`RTCPW_OFS_COUNT); chk("reserved sel", rd, 32'h0);
    // freeze holds the count in debug mode only when enabled
    restart(EN | FRZ | FAST); tick(2, 2);
    debug <= 1'b1; tick(2, 3);
    rdr(`RTCPW_OFS_COUNT); chk("frozen", rd, 32'h2);
    debug <= 1'b0; tick(2, 1);
    rdr(`RTCPW_OFS_COUNT); chk("resumed", rd, 32'h3);
    restart(EN | FAST); debug <= 1'b1; tick(2, 2); debug <= 1'b0;
    rdr(`RTCPW_OFS_COUNT); chk("no freeze", rd, 32'h2);
    // prescalers
    restart(EN | FAST | D32); tick(2, 64);
    rdr(`RTCPW_OFS_COUNT); chk("div32", rd, 32'h2);
    restart(EN | FAST | D512); tick(2, 1024);
    rdr(`RTCPW_OFS_COUNT); chk("div512", rd, 32'h2);
    // compare value 1 matches at count 1024
    restart(EN | CIE | FAST | 32'h0001_0000); tick(2, 1023);
    chk("cmp early", 32'(cirq), 32'h0);
    tick(2, 1);
    chk("cmp irq", 32'(cirq), 32'h1);
    chk("cmp wake", 32'(wake), 32'h1);
    wr(`RTCPW_OFS_CTRL, EN | FAST | 32'h0001_0000); tick(2, 2);
    chk("cmp masked", 32'(cirq), 32'h0);
    rdr(`RTCPW_OFS_STATUS); chk("cmp sticky", rd & 32'h1, 32'h1);
    wr(`RTCPW_OFS_STATUS, 32'h1);
    rdr(`RTCPW_OFS_STATUS); chk("cmp w1c", rd, 32'h0);
    chk("wake clr", 32'(wake), 32'h0);
    // periodic value zero never matches, even when low bits wrap to zero
    restart(EN | FAST | PIE | PEN); tick(2, 1024);
    chk("per zero", 32'(pirq), 32'h0);
    // periodic events only with the periodic enable
    restart(EN | FAST | PIE | 32'h4); tick(2, 16);
    chk("per off", 32'(pirq), 32'h0);
    restart(EN | FAST | PIE | PEN | 32'h4); tick(2, 16);
    chk("per irq", 32'(pirq), 32'h1);
    // clear the periodic flag; next event one full period later
    wr(`RTCPW_OFS_STATUS, 32'h2);
    chk("per clr", 32'(pirq), 32'h0);
    tick(2, 1011);
    chk("per early", 32'(pirq), 32'h0);
    tick(2, 1);
    chk("per period", 32'(pirq), 32'h1);
    wr(`RTCPW_OFS_CTRL, EN | FAST | PEN | 32'h4); tick(2, 1);
    chk("per masked", 32'(pirq), 32'h0);
    wr(`RTCPW_OFS_CTRL, 32'h0);
    rdr(`RTCPW_OFS_STATUS); chk("disable clr", rd, 32'h0);
    results;
  end
endmodule : test_rtcpw_timer
